//--- rtl/adc_serial_cfg.svh
// timing, field and reset constants of the converter serial control block
`ifndef ADC_SERIAL_CFG_SVH
`define ADC_SERIAL_CFG_SVH

// control byte framing
`define CFG_CTRL_BITS        4'h8
`define CFG_TRACK_FIRST_BIT  4'h5
`define CFG_BITCNT_ONE       4'h1
`define CFG_BITCNT_ZERO      4'h0

// result framing
`define CFG_RESULT_BITS      9'h00C
`define CFG_CNT_ZERO         9'h000
`define CFG_CNT_ONE          9'h001
`define CFG_CODE_MSB         11

// core clock and internal conversion time
`define CFG_CLK_PERIOD_NS    20
`define CFG_INT_CONV_NS      7500
`define CFG_INT_CONV_CYCLES  (9'((`CFG_INT_CONV_NS) / (`CFG_CLK_PERIOD_NS)))

// reset values
`define CFG_STROBE_RESET     1'h1
`define CFG_EXT_MODE_RESET   1'h0
`define CFG_SHREG_RESET      8'h00
`define CFG_START_SHREG      8'h01
`define CFG_OUTSR_RESET      12'h000
// synchronised pins until real samples arrive: deselected, clock low
`define CFG_PIN_RESET        3'h4

`endif

//--- rtl/adc_serial_pkg.sv
// types shared by the converter serial control block
package adc_serial_pkg;

  // control byte as it arrives, start bit in the top position
  typedef struct packed {
    logic start;
    logic channel_sel_bit2;
    logic channel_sel_bit1;
    logic channel_sel_bit0;
    logic unipolar;
    logic single_diff_sel;
    logic power_clock_sel_hi;
    logic power_clock_sel_lo;
  } ctrl_byte_t;

  // serial link pins after synchronising
  typedef struct packed {
    logic cs_b;
    logic sclk;
    logic din;
  } link_pins_t;

  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE,
    S_CTRL,
    S_EXT_CONV,
    S_INT_CONV,
    S_INT_OUT
  } seq_state_t;

endpackage : adc_serial_pkg

//--- rtl/pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] pin_i,
  input  wire logic [WIDTH-1:0] reset_val_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [1:0]       primed;

  // one pair of flops per pin; stage1 feeds only stage2
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          stage1[g] <= 1'h0;
          stage2[g] <= 1'h0;
        end
        else
        begin
          stage1[g] <= pin_i[g];
          stage2[g] <= stage1[g];
        end
      end
    end
  endgenerate

  // marks when stage2 holds a real sample; flops reset to constants only
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      primed <= 2'h0;
    else
      primed <= {primed[0], 1'h1};
  end

  // idle levels stand in until then, so no false select or edge follows reset
  assign sync_o = primed[1] ? stage2 : reset_val_i;

endmodule : pin_sync

//--- rtl/adc_serial_control_readout.sv
// serial control and result readout sequencer of a 12-bit SAR converter
// Operation
// - with chip select low, serial clock rises shift the control byte in, one bit per rise
// - leading zeros after chip select falls are ignored; first one is start bit
// - control byte begins with one; lowest two bits both one mean external clock
// - result spans two bytes: one leading zero, twelve bits, three trailing zeros
// - unipolar results are straight binary, bipolar results two's complement
// - output data changes on serial clock falls, most significant bit first
// - host serial clock shifts data in both clock modes
// - input is tracked while the last three control bits shift in
// - lowest two control bits pick the conversion clock mode
// - single-ended when select bit is one, differential pairs when zero
// - external clock mode steps the approximation on the serial clock
// - external mode strobe is high one serial clock period after control byte
// - external mode presents one decision on each of the next 12 falls
// - external mode floats strobe and data while chip select high
// - conversion begins on the serial clock fall after the eighth control bit
// - internal mode strobe drops at conversion start, rises when done
// - lowest two control bits also choose full or fast power-down
`timescale 1ns/1ns
`include "adc_serial_cfg.svh"
module adc_serial_control_readout
  import adc_serial_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  // serial link pins from the host
  input  wire logic        CS_B_I,
  input  wire logic        SCLK_I,
  input  wire logic        DIN_I,
  // code of the selected input from the analog front end, offset binary
  input  wire logic [11:0] ANALOG_CODE_I,
  // serial link outputs with enables
  output logic             DOUT_O,
  output logic             DOUT_OE_O,
  output logic             CONVERSION_STROBE_OUT_O,
  output logic             CONVERSION_STROBE_OUT_OE_O,
  // analog front end control
  output logic             TRACK_O,
  output logic [2:0]       CHANNEL_SEL_O,
  output logic             SINGLE_DIFF_SEL_O,
  output logic             UNIPOLAR_O,
  // mode and power status
  output logic             EXT_CLOCK_MODE_O,
  output logic             CONVERTING_O,
  output logic             FULL_POWER_DOWN_O,
  output logic             FAST_POWER_DOWN_O
);

  link_pins_t pins_s;
  logic       sclk_d;
  logic       sclk_rise;
  logic       sclk_fall;

  // pins are asynchronous to the core clock
  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk_i       (CORE_CLK_I),
    .rst_b_i     (RST_B_I),
    .pin_i       ({CS_B_I, SCLK_I, DIN_I}),
    .reset_val_i (`CFG_PIN_RESET),
    .sync_o      (pins_s)
  );

  // edge finder on the synchronised serial clock
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      sclk_d <= 1'h0;
    else
      sclk_d <= pins_s.sclk;
  end

  assign sclk_rise = pins_s.sclk & ~sclk_d;
  assign sclk_fall = ~pins_s.sclk & sclk_d;

  seq_state_t state, next_state;
  logic [3:0]  bitcnt, next_bitcnt;
  logic [7:0]  shreg, next_shreg;
  ctrl_byte_t  ctrl, next_ctrl;
  logic        ext_mode, next_ext_mode;
  logic [11:0] outsr, next_outsr;
  logic [8:0]  cnt, next_cnt;
  logic        strobe, next_strobe;
  logic        dout, next_dout;
  logic        pd_req, next_pd_req;
  logic        start_seen;
  logic [11:0] coded;

  // start bit: first one clocked in with chip select low
  assign start_seen = ~pins_s.cs_b & sclk_rise & pins_s.din;
  // bipolar flips the msb: offset binary becomes two's complement
  assign coded = ctrl.unipolar ? ANALOG_CODE_I :
                 {~ANALOG_CODE_I[`CFG_CODE_MSB], ANALOG_CODE_I[`CFG_CODE_MSB-1:0]};

  // sequencer next state
  always_comb
  begin
    next_state    = state;
    next_bitcnt   = bitcnt;
    next_shreg    = shreg;
    next_ctrl     = ctrl;
    next_ext_mode = ext_mode;
    next_outsr    = outsr;
    next_cnt      = cnt;
    next_strobe   = strobe;
    next_dout     = dout;
    next_pd_req   = pd_req;
    case (state)
      S_IDLE, S_INT_OUT:
      begin
        // internal mode result drains on falls, zeros follow
        if (state == S_INT_OUT && sclk_fall && !pins_s.cs_b)
        begin
          next_dout  = outsr[`CFG_CODE_MSB];
          next_outsr = {outsr[`CFG_CODE_MSB-1:0], 1'h0};
        end
        // extern mode strobe is driven low once chip select falls
        if (ext_mode && !pins_s.cs_b)
          next_strobe = 1'h0;
        if (start_seen)
        begin
          next_state  = S_CTRL;
          next_shreg  = `CFG_START_SHREG;
          next_bitcnt = `CFG_BITCNT_ONE;
          next_pd_req = 1'h0; // start bit wakes the converter
        end
      end
      S_CTRL:
      begin
        if (pins_s.cs_b)
          next_state = S_IDLE;
        else if (sclk_rise && bitcnt < `CFG_CTRL_BITS)
        begin
          next_shreg  = {shreg[6:0], pins_s.din};
          next_bitcnt = bitcnt + `CFG_BITCNT_ONE;
        end
        else if (sclk_fall && bitcnt == `CFG_CTRL_BITS)
        begin
          // conversion starts on this fall; mode bits decide the clock
          next_ctrl   = ctrl_byte_t'(shreg);
          next_bitcnt = `CFG_BITCNT_ZERO;
          next_cnt    = `CFG_CNT_ZERO;
          next_pd_req = ~shreg[1];
          // power-down codes keep the last clock mode
          if (shreg[1])
            next_ext_mode = shreg[0];
          if (shreg[1] ? shreg[0] : ext_mode)
          begin
            next_state  = S_EXT_CONV;
            next_strobe = 1'h1;
            next_dout   = 1'h0;
          end
          else
          begin
            next_state  = S_INT_CONV;
            next_strobe = 1'h0;
            next_cnt    = `CFG_INT_CONV_CYCLES;
          end
        end
      end
      S_EXT_CONV:
      begin
        if (pins_s.cs_b)
        begin
          next_state  = S_IDLE;
          next_strobe = 1'h0;
        end
        else if (sclk_fall)
        begin
          next_strobe = 1'h0;
          if (cnt == `CFG_CNT_ZERO)
            next_outsr = coded;
          if (cnt < `CFG_RESULT_BITS)
          begin
            // one decision per serial clock, msb first
            next_dout  = (cnt == `CFG_CNT_ZERO) ? coded[`CFG_CODE_MSB]
                                                 : outsr[`CFG_CODE_MSB-1];
            next_outsr = (cnt == `CFG_CNT_ZERO) ? coded
                                                 : {outsr[`CFG_CODE_MSB-1:0], 1'h0};
            next_cnt   = cnt + `CFG_CNT_ONE;
          end
          else
          begin
            next_dout  = 1'h0;
            next_state = S_IDLE;
          end
        end
      end
      S_INT_CONV:
      begin
        // chip select high does not disturb a running internal conversion
        if (cnt == `CFG_CNT_ONE)
        begin
          next_state  = S_INT_OUT;
          next_strobe = 1'h1;
          next_outsr  = coded;
          next_dout   = 1'h0;
        end
        next_cnt = cnt - `CFG_CNT_ONE;
      end
      default:
        next_state = S_IDLE;
    endcase
  end

  // sequencer registers; power-up is internal mode with strobe high
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      state    <= S_IDLE;
      bitcnt   <= `CFG_BITCNT_ZERO;
      shreg    <= `CFG_SHREG_RESET;
      ctrl     <= ctrl_byte_t'(`CFG_SHREG_RESET);
      ext_mode <= `CFG_EXT_MODE_RESET;
      outsr    <= `CFG_OUTSR_RESET;
      cnt      <= `CFG_CNT_ZERO;
      strobe   <= `CFG_STROBE_RESET;
      dout     <= 1'h0;
      pd_req   <= 1'h0;
    end
    else
    begin
      state    <= next_state;
      bitcnt   <= next_bitcnt;
      shreg    <= next_shreg;
      ctrl     <= next_ctrl;
      ext_mode <= next_ext_mode;
      outsr    <= next_outsr;
      cnt      <= next_cnt;
      strobe   <= next_strobe;
      dout     <= next_dout;
      pd_req   <= next_pd_req;
    end
  end

  // pin drivers and front end controls
  assign DOUT_O                     = dout;
  assign DOUT_OE_O                  = ~pins_s.cs_b;
  assign CONVERSION_STROBE_OUT_O    = strobe;
  assign CONVERSION_STROBE_OUT_OE_O = ~ext_mode | ~pins_s.cs_b;
  assign TRACK_O = (state == S_CTRL) && (bitcnt >= `CFG_TRACK_FIRST_BIT)
                   && (bitcnt < `CFG_CTRL_BITS);
  assign CHANNEL_SEL_O     = {ctrl.channel_sel_bit2, ctrl.channel_sel_bit1,
                              ctrl.channel_sel_bit0};
  assign SINGLE_DIFF_SEL_O = ctrl.single_diff_sel;
  assign UNIPOLAR_O        = ctrl.unipolar;
  assign EXT_CLOCK_MODE_O  = ext_mode;
  assign CONVERTING_O      = (state == S_EXT_CONV) || (state == S_INT_CONV);
  // power-down only after the conversion finishes
  assign FULL_POWER_DOWN_O = pd_req & ~CONVERTING_O & ~ctrl.power_clock_sel_lo;
  assign FAST_POWER_DOWN_O = pd_req & ~CONVERTING_O & ctrl.power_clock_sel_lo;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_ctrl_done;
    state == S_CTRL && bitcnt == `CFG_CTRL_BITS && sclk_fall && !pins_s.cs_b;
  endsequence

  // a serial clock fall seen during an external mode conversion
  sequence s_next_fall;
    state == S_EXT_CONV && sclk_fall && !pins_s.cs_b;
  endsequence

  a_start_bit: assert property ((state == S_IDLE) && start_seen |=> state == S_CTRL)
    else $error("start bit not taken");
  a_shift_in: assert property (
    state == S_CTRL && sclk_rise && !pins_s.cs_b && bitcnt < 4'h8
    |=> shreg == {$past(shreg[6:0]), $past(pins_s.din)})
    else $error("control bit not shifted");
  a_conv_start: assert property (s_ctrl_done |=> CONVERTING_O)
    else $error("conversion did not start");
  // pulse: raised after the control byte, held until the next fall, then dropped
  a_ext_strobe: assert property (
    s_ctrl_done ##0 shreg[1:0] == 2'h3 |=> strobe && state == S_EXT_CONV)
    else $error("strobe pulse not raised");
  a_strobe_hold: assert property (
    strobe && state == S_EXT_CONV && !sclk_fall && !pins_s.cs_b |=> strobe)
    else $error("strobe pulse cut short");
  a_strobe_drop: assert property (s_next_fall |=> !strobe)
    else $error("strobe pulse too long");
  a_ext_float: assert property (
    ext_mode && pins_s.cs_b |-> !DOUT_OE_O && !CONVERSION_STROBE_OUT_OE_O)
    else $error("outputs driven with chip select high");
  a_int_strobe: assert property (
    s_ctrl_done ##0 shreg[1:0] == 2'h2 |=> !strobe [*8])
    else $error("internal strobe not low");
  a_int_done: assert property ($rose(strobe) && !ext_mode |-> $past(state) == S_INT_CONV)
    else $error("strobe rose early");
  a_track_window: assert property (TRACK_O |-> state == S_CTRL && bitcnt > 4'h4)
    else $error("tracking outside window");
  a_msb_first: assert property (
    state == S_EXT_CONV && sclk_fall && cnt == 9'h000 && !pins_s.cs_b
    |=> dout == $past(coded[11]))
    else $error("msb not first");
  a_bipolar: assert property (!ctrl.unipolar |-> coded[11] != ANALOG_CODE_I[11])
    else $error("bipolar code not two's complement");
  a_power_mode: assert property (FULL_POWER_DOWN_O |-> !FAST_POWER_DOWN_O && !CONVERTING_O)
    else $error("power-down modes overlap");

endmodule : adc_serial_control_readout

//--- test/spi_host_model.sv
// host side serial master model, clock idle low, bits taken on the rise
`timescale 1ns/1ns
module spi_host_model (
  // core clock that paces the link
  input  wire logic clk_i,
  // converter outputs as seen on the wires
  input  wire logic dout_i,
  input  wire logic strobe_i,
  input  wire logic track_i,
  // link pins driven by the host
  output logic      cs_b_o,
  output logic      sclk_o,
  output logic      din_o
);
  // idle: deselected, clock parked low between frames
  initial
  begin
    cs_b_o = 1'h1;
    sclk_o = 1'h0;
    din_o  = 1'h0;
  end

  // chip select change, then let the synchroniser settle
  task automatic set_cs(input logic lvl);
    @(posedge clk_i);
    cs_b_o <= lvl;
    repeat (4) @(posedge clk_i);
  endtask : set_cs

  // one bit: 4 core clocks low, 4 high; reads on negedge so outputs are settled
  task automatic shift_bit(input logic tx, output logic rx, output logic stb,
                           output logic trk);
    din_o <= tx;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) trk = track_i;
    @(posedge clk_i) sclk_o <= 1'h1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) rx = dout_i;
    stb = strobe_i;
    @(posedge clk_i) sclk_o <= 1'h0;
  endtask : shift_bit

  // one byte, most significant bit first, received byte returned alongside
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      output logic [7:0] stb, output logic [7:0] trk);
    for (int i = 7; i >= 0; i--)
      shift_bit(tx[i], rx[i], stb[i], trk[i]);
  endtask : xfer
endmodule : spi_host_model

//--- test/test_adc_serial_control_readout.sv
// self-checking bench of the converter serial control and readout block
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module test_adc_serial_control_readout
  import adc_serial_pkg::*;
;
  logic        core_clk = 1'h0;
  logic        rst_b    = 1'h0;
  logic [11:0] code     = 12'h000;
  logic        mode     = 1'h0;
  logic        cs_b, sclk, din, dout, dout_oe, stb, stb_oe, track;
  logic        single_diff, unipolar, ext_mode, conv, full_pd, fast_pd;
  logic [2:0]  chan;
  int          n_errors = 0;
  int          n_checks = 0;
  // released outputs float so a stale value cannot pass for data
  wire         dout_line = dout_oe ? dout : 1'bz;
  wire         stb_line  = stb_oe ? stb : 1'bz;

  // 50 MHz core clock
  always #10 core_clk = ~core_clk;

  adc_serial_control_readout u_dut (
    .CORE_CLK_I(core_clk), .RST_B_I(rst_b), .CS_B_I(cs_b), .SCLK_I(sclk),
    .DIN_I(din), .ANALOG_CODE_I(code), .DOUT_O(dout), .DOUT_OE_O(dout_oe),
    .CONVERSION_STROBE_OUT_O(stb), .CONVERSION_STROBE_OUT_OE_O(stb_oe),
    .TRACK_O(track), .CHANNEL_SEL_O(chan), .SINGLE_DIFF_SEL_O(single_diff),
    .UNIPOLAR_O(unipolar), .EXT_CLOCK_MODE_O(ext_mode), .CONVERTING_O(conv),
    .FULL_POWER_DOWN_O(full_pd), .FAST_POWER_DOWN_O(fast_pd)
  );

  spi_host_model u_host (
    .clk_i(core_clk), .dout_i(dout_line), .strobe_i(stb_line), .track_i(track),
    .cs_b_o(cs_b), .sclk_o(sclk), .din_o(din)
  );

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // one whole conversion frame: leading zeros, control byte, two read bytes
  task automatic frame(input logic [7:0] ctrl, input logic [11:0] a);
    ctrl_byte_t  c;
    logic [7:0]  r1, s1, t1, r2, s2, t2, r3, s3;
    logic [11:0] exp;
    int          n;
    time         t0;
    c   = ctrl;
    exp = c.unipolar ? a : {~a[11], a[10:0]};
    code <= a;
    u_host.set_cs(1'h0);
    if (mode)
      `CHK(stb_line, 1'h0)
    // power-down codes keep the clock mode already in force
    if (c.power_clock_sel_hi)
      mode = c.power_clock_sel_lo;
    repeat (3) u_host.shift_bit(1'h0, r1[0], s1[0], t1[0]);
    t0 = $time;
    u_host.xfer(ctrl, r1, s1, t1);
    `CHK(t1, 8'h07)
    if (!mode)
    begin
      repeat (8) @(negedge core_clk);
      `CHK({conv, stb_line}, 2'h2)
      for (n = 8; n < 1000 && stb_line !== 1'h1; n++)
        @(negedge core_clk);
      `CHK(n inside {[375:390]}, 1'h1)
      if (n == 1000)
        summarize();
      @(posedge core_clk);
    end
    u_host.xfer(8'h00, r2, s2, t2);
    u_host.xfer(8'h00, r3, s3, t2);
    `CHK(($time - t0) < 120000, 1'h1)
    `CHK({r2, r3}, {1'h0, exp, 3'h0})
    if (mode)
      `CHK({s2, s3}, 16'h8000)
    `CHK({chan, unipolar, single_diff}, ctrl[6:2])
    `CHK(ext_mode, mode)
    `CHK({full_pd, fast_pd}, c.power_clock_sel_hi ? 2'h0 : {~ctrl[0], ctrl[0]})
    u_host.set_cs(1'h1);
    `CHK({dout_oe, stb_oe}, {1'h0, ~mode})
  endtask : frame

  // reset, then the frames: external, internal, both power-downs, back again
  initial
  begin
    repeat (19) @(posedge core_clk);
    `CHK({stb, stb_oe, ext_mode, dout_oe}, 4'hC)
    @(posedge core_clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge core_clk);
    frame(8'hDF, 12'hA5C);
    frame(8'hA3, 12'h3E1);
    frame(8'hF2, 12'hFFF);
    frame(8'h8C, 12'h001);
    frame(8'hB5, 12'h7FE);
    frame(8'hEF, 12'h800);
    frame(8'hC5, 12'h555);
    summarize();
  end
endmodule : test_adc_serial_control_readout
